// [design/ftr_totalizer_range.sv]
// flow totalizer control, operator screens, remote input and range selection top
//
// Operation
// - start/stop input at default level: low halts counting and pulses, high runs.
// - reset/start input at default level: high clears and holds stopped, low runs.
// - low-active input level setting inverts both start/stop and reset/start meanings.
// - every clear zeroes forward and reverse totals together.
// - totals are kept in non-volatile storage and restored after power returns.
// - sealed configuration allows only start and stop at the panel, never an operator clear; the reset/start input still clears.
// - clear option hidden after a wrong password or when sealed.
// - totalizer key in measurement mode opens the control screen with both totals; displayCount still shows only the total chosen by the range.
// - long clear press prompts; accept clears, decline cancels, escape returns to measurement.
// - bidirectional types display forward total in forward ranges, reverse total in reverse.
// - four range types: uni auto, bi auto, uni external, bi external.
// - external range types take the range from the remote input.
// - each digital output can be enabled on its own; output one shows bit 0 and output two bit 1 of the active range.
// - a range with zero span is unused and never selected unless it is the first range of its direction; automatic selection does not move past it.
// - hysteresis setting and four individual spans steer range switching.
//
// Register access over AHB-Lite and the register offsets were left to the implementer.
module ftr_totalizer_range #(
	parameter int unsigned LONG_CYC = ftr_pkg::LONG_PRESS_CYC,
	parameter int unsigned DEB_CYC = ftr_pkg::DEBOUNCE_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// ahb-lite register slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// operator panel keys
	input wire logic totalizerKey,
	input wire logic clearKey,
	input wire logic startKey,
	input wire logic stopKey,
	input wire logic okKey,
	input wire logic noKey,
	input wire logic escKey,
	input wire logic passwordBad,
	// remote contact
	input wire logic remoteControlInput,
	// flow measurement
	input wire logic countTick,
	input wire logic flowRev,
	input wire logic [15:0] flowMag,
	// non-volatile total store
	input wire logic [31:0] nvLoadFwd,
	input wire logic [31:0] nvLoadRev,
	output logic nvSave,
	output logic [31:0] nvFwd,
	output logic [31:0] nvRev,
	// display and outputs
	output logic [1:0] screenCode,
	output logic clearOffered,
	output logic runIndicator,
	output logic forwardDirectionTag,
	output logic [31:0] displayCount,
	output logic pulseOut,
	output logic digitalOutputOne,
	output logic digitalOutputTwo
);
	logic [ftr_pkg::CTRL_BITS-1:0] ctrl;
	logic [15:0] hyst;
	logic [15:0] span [4];
	logic [31:0] fwdTotal;
	logic [31:0] revTotal;
	logic restored;
	logic runOp;
	logic [31:0] pressCnt;
	logic longHit;
	ftr_pkg::ftr_screen_t screen;
	logic wrPend;
	logic [7:0] wrAddr;
	logic diClean;
	logic [1:0] rangeIdx;

	ftr_pkg::ftr_range_type_t rangeType;
	ftr_pkg::ftr_di_func_t diFunc;
	logic diActive;
	logic diHalt;
	logic diClear;
	logic clearAllowed;
	logic counting;
	logic clearNow;
	logic revSel;
	logic addrPhase;

	// returns the span index for a span offset, or 3'd4 when not a span
	function automatic logic [2:0] spanSlot(input logic [7:0] a);
		if (a >= ftr_pkg::OFF_SPAN0 && a <= ftr_pkg::OFF_SPAN3 && a[1:0] == 2'b00) begin
			return 3'(((a - ftr_pkg::OFF_SPAN0) >> 2));
		end
		return 3'd4;
	endfunction

	always_comb begin
		rangeType = ftr_pkg::ftr_range_type_t'(ctrl[ftr_pkg::CTRL_TYPE_LSB +: 2]);
		diFunc = ftr_pkg::ftr_di_func_t'(ctrl[ftr_pkg::CTRL_DIFN_LSB +: 2]);
		diActive = diClean ^ ctrl[ftr_pkg::CTRL_LOWACT];
		diHalt = (diFunc == ftr_pkg::DI_START_STOP) && !diActive;
		diClear = (diFunc == ftr_pkg::DI_RESET_START) && diActive;
		clearAllowed = !ctrl[ftr_pkg::CTRL_SEALED] && !passwordBad;
		counting = restored && runOp && !diHalt && !diClear;
		clearNow = diClear || (screen == ftr_pkg::SCR_CONFIRM && okKey && clearAllowed);
		revSel = ftr_pkg::isBi(rangeType) && rangeIdx[1];
		addrPhase = hsel && hready && htrans[1];
		longHit = pressCnt >= LONG_CYC - 1;
	end

	ftr_debounce #(
		.DEB_CYC(DEB_CYC)
	) u_debounce (
		.clk(clk),
		.arst_n(arst_n),
		.din(remoteControlInput),
		.dout(diClean)
	);

	ftr_range_sel u_range (
		.clk(clk),
		.arst_n(arst_n),
		.rangeType(rangeType),
		.span(span),
		.hyst(hyst),
		.flowMag(flowMag),
		.flowRev(flowRev),
		.extSelect(diFunc == ftr_pkg::DI_RANGE_SELECT && diActive),
		.rangeIdx(rangeIdx)
	);

	// bus address phase capture; zero wait states, always okay
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wrPend <= 1'b0;
			wrAddr <= 8'h00;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			wrPend <= addrPhase && hwrite;
			wrAddr <= haddr[7:0];
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// read data registered during the address phase, unmapped reads zero
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hrdata <= 32'h0000_0000;
		end else if (addrPhase && !hwrite) begin
			hrdata <= 32'h0000_0000;
			if (haddr[31:8] == 24'h00_0000) begin
				case (haddr[7:0])
					ftr_pkg::OFF_CTRL: hrdata <= {24'h00_0000, ctrl};
					ftr_pkg::OFF_HYST: hrdata <= {16'h0000, hyst};
					ftr_pkg::OFF_FWD: hrdata <= fwdTotal;
					ftr_pkg::OFF_REV: hrdata <= revTotal;
					ftr_pkg::OFF_STAT: begin
						hrdata[ftr_pkg::STAT_RUN] <= counting;
						hrdata[ftr_pkg::STAT_SCR_LSB +: 2] <= screen;
						hrdata[ftr_pkg::STAT_RANGE_LSB +: 2] <= rangeIdx;
						hrdata[ftr_pkg::STAT_REVSEL] <= revSel;
						hrdata[ftr_pkg::STAT_CLROFF] <= clearAllowed;
					end
					default: begin
						if (spanSlot(haddr[7:0]) != 3'd4) begin
							hrdata <= {16'h0000, span[2'(spanSlot(haddr[7:0]))]};
						end
					end
				endcase
			end
		end
	end

	// configuration writes in the data phase
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl <= ftr_pkg::CTRL_RST;
			hyst <= ftr_pkg::HYST_RST;
			for (int i = 0; i < 4; i++) begin
				span[i] <= ftr_pkg::SPAN_RST;
			end
		end else if (wrPend) begin
			if (wrAddr == ftr_pkg::OFF_CTRL) begin
				ctrl <= hwdata[ftr_pkg::CTRL_BITS-1:0];
			end
			if (wrAddr == ftr_pkg::OFF_HYST) begin
				hyst <= hwdata[15:0];
			end
			if (spanSlot(wrAddr) != 3'd4) begin
				span[2'(spanSlot(wrAddr))] <= hwdata[15:0];
			end
		end
	end

	// totals: restored once after reset, cleared together, counted per direction
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			restored <= 1'b0;
			fwdTotal <= 32'h0000_0000;
			revTotal <= 32'h0000_0000;
		end else if (!restored) begin
			restored <= 1'b1;
			fwdTotal <= nvLoadFwd;
			revTotal <= nvLoadRev;
		end else if (clearNow) begin
			fwdTotal <= 32'h0000_0000;
			revTotal <= 32'h0000_0000;
		end else if (counting && countTick) begin
			if (flowRev) begin
				revTotal <= revTotal + 32'h0000_0001;
			end else begin
				fwdTotal <= fwdTotal + 32'h0000_0001;
			end
		end
	end

	// every change of the totals is pushed to the non-volatile store
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			nvSave <= 1'b0;
		end else begin
			nvSave <= restored && (clearNow || (counting && countTick));
		end
	end

	assign nvFwd = fwdTotal;
	assign nvRev = revTotal;

	// operator start and stop, allowed even when sealed
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			runOp <= 1'b1;
		end else if (screen == ftr_pkg::SCR_CONTROL) begin
			if (startKey) begin
				runOp <= 1'b1;
			end else if (stopKey) begin
				runOp <= 1'b0;
			end
		end
	end

	// long press timer of the clear key
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pressCnt <= 32'h0000_0000;
		end else if (screen == ftr_pkg::SCR_CONTROL && clearKey && clearAllowed && !longHit) begin
			pressCnt <= pressCnt + 32'h0000_0001;
		end else if (!(screen == ftr_pkg::SCR_CONTROL && clearKey)) begin
			pressCnt <= 32'h0000_0000;
		end
	end

	// operator screen sequence
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			screen <= ftr_pkg::SCR_MEASURE;
		end else begin
			case (screen)
				ftr_pkg::SCR_MEASURE: begin
					if (totalizerKey) begin
						screen <= ftr_pkg::SCR_CONTROL;
					end
				end
				ftr_pkg::SCR_CONTROL: begin
					if (escKey) begin
						screen <= ftr_pkg::SCR_MEASURE;
					end else if (longHit && clearKey && clearAllowed) begin
						screen <= ftr_pkg::SCR_CONFIRM;
					end
				end
				ftr_pkg::SCR_CONFIRM: begin
					if (escKey) begin
						screen <= ftr_pkg::SCR_MEASURE;
					end else if (okKey || noKey) begin
						screen <= ftr_pkg::SCR_CONTROL;
					end
				end
				default: screen <= ftr_pkg::SCR_MEASURE;
			endcase
		end
	end

	// registered display and output pins
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			screenCode <= 2'b00;
			clearOffered <= 1'b0;
			runIndicator <= 1'b0;
			forwardDirectionTag <= 1'b1;
			displayCount <= 32'h0000_0000;
			pulseOut <= 1'b0;
			digitalOutputOne <= 1'b0;
			digitalOutputTwo <= 1'b0;
		end else begin
			screenCode <= screen;
			clearOffered <= clearAllowed && screen != ftr_pkg::SCR_MEASURE;
			runIndicator <= counting;
			forwardDirectionTag <= !revSel;
			displayCount <= revSel ? revTotal : fwdTotal;
			pulseOut <= counting && countTick;
			digitalOutputOne <= ctrl[ftr_pkg::CTRL_DO1] && rangeIdx[0];
			digitalOutputTwo <= ctrl[ftr_pkg::CTRL_DO2] && rangeIdx[1];
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	a_startstop_halt: assert property (
		diFunc == ftr_pkg::DI_START_STOP && !diActive |=> !pulseOut && !runIndicator)
		else $error("start/stop low did not halt");
	a_reset_clears: assert property (
		restored && diFunc == ftr_pkg::DI_RESET_START && diActive ##1 diActive
		|-> fwdTotal == 32'h0000_0000 && revTotal == 32'h0000_0000 && !counting)
		else $error("reset/start did not clear and hold");
	a_level_invert: assert property (
		diFunc == ftr_pkg::DI_START_STOP && ctrl[ftr_pkg::CTRL_LOWACT] && diClean |=> !runIndicator)
		else $error("low-active level not inverted");
	a_clear_both: assert property (
		restored && clearNow |=> fwdTotal == 32'h0000_0000 && revTotal == 32'h0000_0000 && nvSave)
		else $error("totals not cleared together");
	a_sealed_noclear: assert property (
		ctrl[ftr_pkg::CTRL_SEALED] && screen == ftr_pkg::SCR_CONTROL && !wrPend
		|=> screen != ftr_pkg::SCR_CONFIRM)
		else $error("sealed unit reached clear prompt");
	a_key_opens: assert property (
		screen == ftr_pkg::SCR_MEASURE && totalizerKey |=> screen == ftr_pkg::SCR_CONTROL
		##1 screenCode == ftr_pkg::SCR_CONTROL)
		else $error("totalizer key did not open control screen");
	a_run_flag: assert property (
		counting |=> runIndicator)
		else $error("run indicator wrong");
	a_escape_confirm: assert property (
		screen == ftr_pkg::SCR_CONFIRM && escKey |=> screen == ftr_pkg::SCR_MEASURE)
		else $error("escape did not return to measurement");
	a_display_select: assert property (
		revSel |=> displayCount == $past(revTotal) && !forwardDirectionTag)
		else $error("display shows wrong direction");
	a_range_output: assert property (
		ctrl[ftr_pkg::CTRL_DO1] && ctrl[ftr_pkg::CTRL_DO2]
		|=> {digitalOutputTwo, digitalOutputOne} == $past(rangeIdx))
		else $error("range outputs do not match range");

	c_operator_clear: cover property (screen == ftr_pkg::SCR_CONFIRM && okKey && clearAllowed);
	c_remote_reset: cover property (diClear ##1 !diClear);
	c_range_up: cover property (rangeIdx == 2'd0 ##1 rangeIdx == 2'd1);
	c_reverse_display: cover property (revSel && countTick && counting);
endmodule

// [design/ftr_pkg.sv]
// shared constants, types and helpers of the flow totalizer and range control block
package ftr_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_HYST = 8'h04;
	localparam logic [7:0] OFF_SPAN0 = 8'h08;
	localparam logic [7:0] OFF_SPAN3 = 8'h14;
	localparam logic [7:0] OFF_FWD = 8'h18;
	localparam logic [7:0] OFF_REV = 8'h1C;
	localparam logic [7:0] OFF_STAT = 8'h20;
	// control register fields
	localparam int CTRL_TYPE_LSB = 0;
	localparam int CTRL_DIFN_LSB = 2;
	localparam int CTRL_LOWACT = 4;
	localparam int CTRL_SEALED = 5;
	localparam int CTRL_DO1 = 6;
	localparam int CTRL_DO2 = 7;
	localparam int CTRL_BITS = 8;
	// status register fields
	localparam int STAT_RUN = 0;
	localparam int STAT_SCR_LSB = 1;
	localparam int STAT_RANGE_LSB = 3;
	localparam int STAT_REVSEL = 5;
	localparam int STAT_CLROFF = 6;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [15:0] HYST_RST = 16'h0000;
	localparam logic [15:0] SPAN_RST = 16'h0000;
	// timing
	localparam int unsigned CLK_HZ = 125000000;
	localparam int unsigned LONG_PRESS_MS = 1000;
	localparam int unsigned DEBOUNCE_MS = 10;
	localparam int unsigned LONG_PRESS_CYC = LONG_PRESS_MS * (CLK_HZ / 1000);
	localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
	typedef enum logic [1:0] {
		UNI_AUTO_FOUR_RANGE,
		BI_AUTO_TWO_TWO_RANGE,
		UNI_EXTERNAL_RANGE,
		BI_EXTERNAL_RANGE
	} ftr_range_type_t;
	typedef enum logic [1:0] {
		DI_NONE,
		DI_START_STOP,
		DI_RESET_START,
		DI_RANGE_SELECT
	} ftr_di_func_t;
	typedef enum logic [1:0] {
		SCR_MEASURE,
		SCR_CONTROL,
		SCR_CONFIRM
	} ftr_screen_t;
	// bidirectional types keep ranges 3 and 4 for reverse flow
	function automatic logic isBi(input ftr_range_type_t t);
		return (t == BI_AUTO_TWO_TWO_RANGE) || (t == BI_EXTERNAL_RANGE);
	endfunction
	// a zero span marks a range as unused
	function automatic logic spanUsed(input logic [15:0] s);
		return s != 16'h0000;
	endfunction
endpackage

// [design/ftr_debounce.sv]
// two-flop synchroniser and stability debouncer for the remote contact input
module ftr_debounce #(
	parameter int unsigned DEB_CYC = ftr_pkg::DEBOUNCE_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// raw and clean level
	input wire logic din,
	output logic dout
);
	logic syncA;
	logic syncB;
	logic [31:0] stableCnt;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			syncA <= 1'b0;
			syncB <= 1'b0;
		end else begin
			syncA <= din;
			syncB <= syncA;
		end
	end

	// output follows only after the new level held for DEB_CYC cycles
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			stableCnt <= 32'h0000_0000;
			dout <= 1'b0;
		end else if (syncB == dout) begin
			stableCnt <= 32'h0000_0000;
		end else if (stableCnt >= DEB_CYC - 1) begin
			stableCnt <= 32'h0000_0000;
			dout <= syncB;
		end else begin
			stableCnt <= stableCnt + 32'h0000_0001;
		end
	end
endmodule

// [design/ftr_range_sel.sv]
// active measurement range selection, automatic with hysteresis or external
module ftr_range_sel (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// configuration
	input wire ftr_pkg::ftr_range_type_t rangeType,
	input wire logic [15:0] span [4],
	input wire logic [15:0] hyst,
	// measurement and external select
	input wire logic [15:0] flowMag,
	input wire logic flowRev,
	input wire logic extSelect,
	// active range, 0 to 3 for ranges 1 to 4
	output logic [1:0] rangeIdx
);
	logic [1:0] base;
	logic [1:0] top;
	logic autoSel;
	logic [16:0] downLevel;

	always_comb begin
		autoSel = (rangeType == ftr_pkg::UNI_AUTO_FOUR_RANGE) || (rangeType == ftr_pkg::BI_AUTO_TWO_TWO_RANGE);
		base = (ftr_pkg::isBi(rangeType) && flowRev) ? 2'd2 : 2'd0;
		top = (rangeType == ftr_pkg::UNI_AUTO_FOUR_RANGE) ? 2'd3 : base + 2'd1;
		downLevel = (rangeIdx > base) ? {1'b0, span[rangeIdx - 2'd1]} : 17'h0_0000;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rangeIdx <= 2'd0;
		end else if (!autoSel) begin
			rangeIdx <= base + {1'b0, extSelect && ftr_pkg::spanUsed(span[base + 2'd1])};
		end else if (rangeIdx < base || rangeIdx > top) begin
			rangeIdx <= base;
		end else if (rangeIdx < top && ftr_pkg::spanUsed(span[rangeIdx + 2'd1]) && flowMag > span[rangeIdx]) begin
			rangeIdx <= rangeIdx + 2'd1;
		end else if (rangeIdx > base && {1'b0, flowMag} + {1'b0, hyst} < downLevel) begin
			rangeIdx <= rangeIdx - 2'd1;
		end
	end

	a_auto_skip_unused: assert property (@(posedge clk) disable iff (!arst_n)
		autoSel && rangeIdx == base && !ftr_pkg::spanUsed(span[base + 2'd1]) && !flowRev && base == 2'd0
		|=> rangeIdx == 2'd0)
		else $error("unused range was selected");
endmodule

// [tb/ftr_panel_model.sv]
// operator panel keys and remote contact driving the totalizer block
module ftr_panel_model (
	// clock
	input wire logic clk,
	// panel keys
	output logic totalizerKey,
	output logic clearKey,
	output logic startKey,
	output logic stopKey,
	output logic okKey,
	output logic noKey,
	output logic escKey,
	// remote contact
	output logic remoteControlInput
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] tap;
	initial begin
		tap = 6'h00;
		clearKey = 1'b0;
		remoteControlInput = 1'b0;
	end
	// tap order: totalizer, start, stop, ok, no, esc
	assign totalizerKey = tap[0];
	assign startKey = tap[1];
	assign stopKey = tap[2];
	assign okKey = tap[3];
	assign noKey = tap[4];
	assign escKey = tap[5];
	// one-cycle key press, released after the sampling edge
	task automatic press(input int k);
		@(posedge clk);
		tap <= 6'h01 << k;
		@(posedge clk);
		tap <= 6'h00;
	endtask
	// clear key held for n edges, then let go
	task automatic holdClear(input int n);
		@(posedge clk);
		clearKey <= 1'b1;
		repeat (n) @(posedge clk);
		clearKey <= 1'b0;
	endtask
	// contact level stays until changed again
	task automatic setRemote(input logic v);
		@(posedge clk);
		remoteControlInput <= v;
	endtask
endmodule

// [tb/ftr_totalizer_range_bench.sv]
// self-checking bench of the flow totalizer and range control block
module ftr_totalizer_range_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LC = 8;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic hsel, hwrite, hreadyout, hresp, countTick, flowRev, passwordBad, nvSave;
	logic [31:0] haddr, hwdata, hrdata, nvLoadFwd, nvLoadRev, nvFwd, nvRev, displayCount, fwd, rev;
	logic [1:0] htrans, screenCode;
	logic [2:0] hsize;
	logic [15:0] flowMag, seed;
	logic tk, ck, sk, pk, ok, nk, ek, rci, clearOffered, runIndicator, forwardDirectionTag, pulseOut, do1, do2;
	int n_fail = 0;
	int checked = 0;
	int pulses = 0;
	int saves = 0;
	always #4 clk = ~clk;
	always @(posedge clk) if (pulseOut === 1'b1) pulses++;
	always @(posedge clk) if (nvSave === 1'b1) saves++;
	ftr_panel_model u_pm (.clk(clk), .totalizerKey(tk), .clearKey(ck), .startKey(sk), .stopKey(pk),
		.okKey(ok), .noKey(nk), .escKey(ek), .remoteControlInput(rci));
	ftr_totalizer_range #(.LONG_CYC(LC), .DEB_CYC(4)) u_dut (.clk(clk), .arst_n(arst_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .totalizerKey(tk), .clearKey(ck),
		.startKey(sk), .stopKey(pk), .okKey(ok), .noKey(nk), .escKey(ek), .passwordBad(passwordBad),
		.remoteControlInput(rci), .countTick(countTick), .flowRev(flowRev), .flowMag(flowMag),
		.nvLoadFwd(nvLoadFwd), .nvLoadRev(nvLoadRev), .nvSave(nvSave), .nvFwd(nvFwd), .nvRev(nvRev),
		.screenCode(screenCode), .clearOffered(clearOffered), .runIndicator(runIndicator),
		.forwardDirectionTag(forwardDirectionTag), .displayCount(displayCount), .pulseOut(pulseOut),
		.digitalOutputOne(do1), .digitalOutputTwo(do2));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// control word from type, input function, low-active, sealed and range outputs
	function automatic logic [31:0] ctl(input int t, input int f, input bit la, input bit se, input bit dd);
		logic [31:0] c;
		c = 32'h0;
		c[ftr_pkg::CTRL_TYPE_LSB +: 2] = t[1:0];
		c[ftr_pkg::CTRL_DIFN_LSB +: 2] = f[1:0];
		c[ftr_pkg::CTRL_LOWACT] = la;
		c[ftr_pkg::CTRL_SEALED] = se;
		c[ftr_pkg::CTRL_DO1] = dd;
		c[ftr_pkg::CTRL_DO2] = dd;
		return c;
	endfunction
	// range index per type with contact active, reverse flow on bidirectional types
	function automatic logic [31:0] typeIdx(input int t);
		return (t == 0) ? 32'h1 : (t == 1) ? 32'h2 : (t == 2) ? 32'h1 : 32'h3;
	endfunction
	task automatic test_done;
		if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
			n_fail++;
		end
	endtask
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		hsize <= 3'h2;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		d = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] d;
		ahb(1'b1, a, wd, d);
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		ahb(1'b0, a, 32'h0, d);
		chk(d, exp);
	endtask
	task automatic idxChk(input logic [31:0] exp);
		logic [31:0] d;
		repeat (12) @(posedge clk);
		ahb(1'b0, ftr_pkg::OFF_STAT, 32'h0, d);
		chk({30'h0, d[ftr_pkg::STAT_RANGE_LSB +: 2]}, exp);
		chk({30'h0, do2, do1}, exp);
	endtask
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clk) countTick <= 1'b1;
			@(posedge clk) countTick <= 1'b0;
		end
		repeat (3) @(posedge clk);
	endtask
	task automatic tots();
		rdChk(ftr_pkg::OFF_FWD, fwd);
		rdChk(ftr_pkg::OFF_REV, rev);
	endtask
	initial begin
		repeat (30000) @(posedge clk);
		n_fail++;
		test_done();
	end
	initial begin
		{hsel, hwrite, countTick, flowRev, passwordBad} = 5'h00;
		{haddr, hwdata, htrans, hsize, flowMag} = {64'h0, 2'h0, 3'h2, 16'h0};
		seed = 16'hDD97;
		nvLoadFwd = {16'h0, seed};
		seed = lfsr(seed);
		nvLoadRev = {16'h0, seed};
		{fwd, rev} = {nvLoadFwd, nvLoadRev};
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		tots();
		rdChk(ftr_pkg::OFF_CTRL, 32'h0);
		rdChk(ftr_pkg::OFF_SPAN3, 32'h0);
		rdChk(8'h40, 32'h0);
		wr(ftr_pkg::OFF_FWD, 32'h5A5A);
		rdChk(ftr_pkg::OFF_FWD, fwd);
		for (int i = 0; i < 2; i++) begin
			seed = lfsr(seed);
			flowRev <= i[0];
			ticks(seed[2:0] + 1);
			if (i == 0) fwd += seed[2:0] + 1;
			else rev += seed[2:0] + 1;
		end
		flowRev <= 1'b0;
		tots();
		chk(nvFwd, fwd);
		chk(nvRev, rev);
		chk(pulses, fwd + rev - nvLoadFwd - nvLoadRev);
		chk(saves, pulses);
		u_pm.press(0);
		repeat (3) @(posedge clk);
		chk(screenCode, 32'h1);
		chk(clearOffered, 32'h1);
		u_pm.press(2);
		ticks(3);
		chk(runIndicator, 32'h0);
		rdChk(ftr_pkg::OFF_FWD, fwd);
		u_pm.press(1);
		repeat (3) @(posedge clk);
		chk(runIndicator, 32'h1);
		u_pm.holdClear(LC + 2);
		repeat (3) @(posedge clk);
		chk(screenCode, 32'h2);
		u_pm.press(4);
		repeat (3) @(posedge clk);
		chk(screenCode, 32'h1);
		tots();
		u_pm.holdClear(LC + 2);
		u_pm.press(3);
		repeat (3) @(posedge clk);
		{fwd, rev} = 64'h0;
		tots();
		u_pm.press(5);
		repeat (3) @(posedge clk);
		chk(screenCode, 32'h0);
		wr(ftr_pkg::OFF_CTRL, ctl(0, 0, 0, 1, 0));
		ticks(2);
		fwd += 2;
		u_pm.press(0);
		u_pm.holdClear(LC + 2);
		repeat (3) @(posedge clk);
		chk(clearOffered, 32'h0);
		chk(screenCode, 32'h1);
		u_pm.press(2);
		repeat (3) @(posedge clk);
		chk(runIndicator, 32'h0);
		u_pm.press(1);
		u_pm.press(5);
		wr(ftr_pkg::OFF_CTRL, 32'h0);
		passwordBad <= 1'b1;
		u_pm.press(0);
		repeat (3) @(posedge clk);
		chk(clearOffered, 32'h0);
		passwordBad <= 1'b0;
		u_pm.press(5);
		tots();
		for (int la = 0; la < 2; la++) begin
			wr(ftr_pkg::OFF_CTRL, ctl(0, 1, la, 0, 0));
			u_pm.setRemote(la[0]);
			repeat (12) @(posedge clk);
			ticks(2);
			rdChk(ftr_pkg::OFF_FWD, fwd);
			u_pm.setRemote(!la[0]);
			repeat (12) @(posedge clk);
			ticks(2);
			fwd += 2;
			rdChk(ftr_pkg::OFF_FWD, fwd);
			wr(ftr_pkg::OFF_CTRL, ctl(0, 2, la, 0, 0));
			repeat (3) @(posedge clk);
			ticks(2);
			{fwd, rev} = 64'h0;
			tots();
			u_pm.setRemote(la[0]);
			repeat (12) @(posedge clk);
			ticks(2);
			fwd = 2;
			rdChk(ftr_pkg::OFF_FWD, fwd);
		end
		seed = lfsr(seed);
		nvLoadFwd <= {16'h0, seed};
		nvLoadRev <= {seed, 16'h0};
		arst_n <= 1'b0;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		{fwd, rev} = {16'h0, seed, seed, 16'h0};
		tots();
		rdChk(ftr_pkg::OFF_CTRL, 32'h0);
		for (int k = 0; k < 4; k++) wr(8'(ftr_pkg::OFF_SPAN0 + 4 * k), 32'h1000 * (k + 1));
		wr(ftr_pkg::OFF_HYST, 32'h0100);
		wr(ftr_pkg::OFF_CTRL, ctl(0, 0, 0, 0, 1));
		seed = lfsr(seed);
		flowMag <= 16'h2001 + {4'h0, seed[11:0]};
		idxChk(32'h2);
		flowMag <= 16'h1F80;
		idxChk(32'h2);
		flowMag <= 16'h1E00;
		idxChk(32'h1);
		flowMag <= 16'h0000;
		idxChk(32'h0);
		wr(8'(ftr_pkg::OFF_SPAN0 + 4), 32'h0);
		seed = lfsr(seed);
		flowMag <= {2'b11, seed[13:0]};
		idxChk(32'h0);
		wr(8'(ftr_pkg::OFF_SPAN0 + 4), 32'h2000);
		u_pm.setRemote(1'b1);
		for (int t = 0; t < 4; t++) begin
			wr(ftr_pkg::OFF_CTRL, ctl(t, 3, 0, 0, 1));
			flowRev <= t[0];
			flowMag <= t[0] ? 16'h0100 : 16'h1800;
			idxChk(typeIdx(t));
			chk(forwardDirectionTag, {31'h0, !t[0]});
			chk(displayCount, t[0] ? rev : fwd);
		end
		test_done();
	end
endmodule
